// ---- logic/fwek_pkg.sv ----
// Package: register map, fields, key codes and Flash timing for the Flash write/erase block
package fwek_pkg;
  localparam logic [7:0] PSC_ADDR = 8'h8F;
  localparam logic [7:0] KEY_ADDR = 8'hB6;
  localparam logic [7:0] PSC_RESET = 8'h00;
  localparam logic [7:0] KEY_RESET = 8'h00;
  localparam int SCRATCHPAD_SELECT_BIT = 2;
  localparam int ERASE_BIT = 1;
  localparam int WRITE_BIT = 0;
  localparam logic [7:0] KEY_FIRST = 8'hA5;
  localparam logic [7:0] KEY_SECOND = 8'hF1;
  localparam int CLK_MHZ = 250;
  // Flash busy times in microseconds; cycle counts derived below
  localparam int WRITE_TIME_US = 60;
  localparam int ERASE_TIME_US = 30000;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;

  typedef enum logic [1:0] {
    FWEK_LOCKED = 2'b00,
    FWEK_FIRST = 2'b01,
    FWEK_OPEN = 2'b10,
    FWEK_DEAD = 2'b11
  } fwek_lock_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fwek_sfr_t;

  typedef struct packed {
    logic req;
    logic erase;
    logic scratch;
    logic [15:0] addr;
    logic [7:0] data;
  } fwek_flash_t;
endpackage

// ---- logic/fwek_busy_timer.sv ----
// Busy-time counter for one Flash write or page erase
`timescale 1ns/100ps
module fwek_busy_timer #(
  parameter int WIDTH = 24
) (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Control
  input wire logic start,
  input wire logic [WIDTH-1:0] load,
  output logic busy
);
  logic [WIDTH-1:0] cnt_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      if (start) begin
        cnt_q <= load;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign busy = (cnt_q != '0);
endmodule

// ---- logic/fwek_flash_ctrl.sv ----
// Flash write/erase control: select/enable register, unlock key and CPU stall
`timescale 1ns/100ps
// Behaviour
// - Control register bits 7:3 read as zero and ignore writes.
// - With scratchpad select set, code reads and Flash writes go to the scratchpad sector.
// - With scratchpad select clear, accesses go to the main Flash sector.
// - With erase and write enables both set, a data-move write erases the addressed page.
// - With erase enable clear, page erase is disabled.
// - With write enable set and erase enable clear a data-move write programs one byte; write enable clear disables it.
// - Writes and erases open only after key 0xA5 then directly 0xF1.
// - After one write or erase completes, the lock closes again.
// - A wrong or out-of-order key write locks Flash until reset.
// - A write or erase attempted while locked locks Flash until reset.
// - Key register reads 00 locked, 01 first key seen, 10 unlocked in bits 1:0.
// - Key register reads 11 when locked until reset.
// - A write or erase without supply monitor and its reset enabled raises a Flash error reset.
module fwek_flash_ctrl #(
  parameter int WRITE_CYCLES = fwek_pkg::WRITE_CYCLES,
  parameter int ERASE_CYCLES = fwek_pkg::ERASE_CYCLES
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Special-function register port
  input wire fwek_pkg::fwek_sfr_t sfr,
  output logic [7:0] sfr_rdata,
  // Data-move write and code read from the core
  input wire logic xwr_req,
  input wire logic [15:0] xwr_addr,
  input wire logic [7:0] xwr_data,
  input wire logic code_rd,
  // Supply monitor state
  input wire logic vmon_enabled,
  input wire logic vmon_reset_enabled,
  // Towards the Flash array
  output fwek_pkg::fwek_flash_t flash,
  output logic code_scratch,
  output logic xwr_to_flash,
  // To core and reset logic
  output logic cpu_stall,
  output logic flash_error_reset
);
  localparam int TW = $clog2(ERASE_CYCLES + 1);

  logic [2:0] psc_q;
  fwek_pkg::fwek_lock_t lock_q;
  logic [7:0] rdata_q;
  fwek_pkg::fwek_flash_t flash_q;
  logic ferr_q;
  logic busy;
  logic busy_d1_q;
  logic key_wr;
  logic attempt;
  logic start;
  logic done;
  fwek_pkg::fwek_lock_t lock_now;

  assign key_wr = sfr.wr && sfr.addr == fwek_pkg::KEY_ADDR;
  // A data-move write is a Flash request only while write enable is set
  assign attempt = xwr_req && psc_q[fwek_pkg::WRITE_BIT] && !busy;
  // Missing supply protection blocks the operation outright
  assign start = attempt && lock_now == fwek_pkg::FWEK_OPEN &&
    vmon_enabled && vmon_reset_enabled;
  assign done = busy_d1_q && !busy;
  // The lock register still reads unlocked in the cycle after the count ends; folding the
  // relock in here keeps a data-move write in that cycle from reusing the spent key
  assign lock_now = (done && lock_q == fwek_pkg::FWEK_OPEN) ?
    fwek_pkg::FWEK_LOCKED : lock_q;

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      psc_q <= fwek_pkg::PSC_RESET[2:0];
    end else if (clk_en && sfr.wr && sfr.addr == fwek_pkg::PSC_ADDR) begin
      psc_q <= sfr.wdata[2:0];
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lock_q <= fwek_pkg::FWEK_LOCKED;
    end else if (clk_en) begin
      if (lock_now == fwek_pkg::FWEK_DEAD) begin
        lock_q <= fwek_pkg::FWEK_DEAD;
      end else if (attempt && lock_now != fwek_pkg::FWEK_OPEN) begin
        lock_q <= fwek_pkg::FWEK_DEAD;
      end else if (key_wr) begin
        unique case (lock_now)
          fwek_pkg::FWEK_LOCKED: lock_q <= (sfr.wdata == fwek_pkg::KEY_FIRST) ?
            fwek_pkg::FWEK_FIRST : fwek_pkg::FWEK_DEAD;
          fwek_pkg::FWEK_FIRST: lock_q <= (sfr.wdata == fwek_pkg::KEY_SECOND) ?
            fwek_pkg::FWEK_OPEN : fwek_pkg::FWEK_DEAD;
          fwek_pkg::FWEK_OPEN: lock_q <= fwek_pkg::FWEK_DEAD;
          default: lock_q <= fwek_pkg::FWEK_DEAD;
        endcase
      end else begin
        lock_q <= lock_now;
      end
    end
  end

  // Register reads come from a flop, one cycle after the strobe
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rdata_q <= 8'h00;
    end else if (clk_en && sfr.rd) begin
      if (sfr.addr == fwek_pkg::PSC_ADDR) begin
        rdata_q <= {5'b00000, psc_q};
      end else if (sfr.addr == fwek_pkg::KEY_ADDR) begin
        rdata_q <= {6'h00, lock_now};
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      flash_q <= '0;
    end else if (clk_en) begin
      flash_q.req <= start;
      if (start) begin
        flash_q.erase <= psc_q[fwek_pkg::ERASE_BIT];
        flash_q.scratch <= psc_q[fwek_pkg::SCRATCHPAD_SELECT_BIT];
        flash_q.addr <= xwr_addr;
        flash_q.data <= xwr_data;
      end
    end
  end

  // Error reset pulses when an attempt finds supply protection off
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ferr_q <= 1'b0;
    end else if (clk_en) begin
      ferr_q <= attempt && !(vmon_enabled && vmon_reset_enabled);
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      busy_d1_q <= 1'b0;
    end else if (clk_en) begin
      busy_d1_q <= busy;
    end
  end

  fwek_busy_timer #(.WIDTH(TW)) u_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .clk_en(clk_en),
    .start(start),
    .load(psc_q[fwek_pkg::ERASE_BIT] ? TW'(ERASE_CYCLES) : TW'(WRITE_CYCLES)),
    .busy(busy)
  );

  assign sfr_rdata = rdata_q;
  assign flash = flash_q;
  assign code_scratch = psc_q[fwek_pkg::SCRATCHPAD_SELECT_BIT] && code_rd;
  assign xwr_to_flash = psc_q[fwek_pkg::WRITE_BIT];
  assign cpu_stall = busy || start;
  assign flash_error_reset = ferr_q;

  AST_DEAD_STAYS: assert property (@(posedge sys_clk) disable iff (reset)
    lock_q == fwek_pkg::FWEK_DEAD |=> lock_q == fwek_pkg::FWEK_DEAD)
    else $error("permanent lock left");
  AST_BAD_KEY: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && key_wr && lock_q == fwek_pkg::FWEK_LOCKED && sfr.wdata != fwek_pkg::KEY_FIRST
    |=> lock_q == fwek_pkg::FWEK_DEAD)
    else $error("wrong first key did not lock");
  AST_LOCKED_ATTEMPT: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && attempt && lock_q != fwek_pkg::FWEK_OPEN |=> lock_q == fwek_pkg::FWEK_DEAD)
    else $error("locked attempt did not lock");
  AST_NO_START_LOCKED: assert property (@(posedge sys_clk) disable iff (reset)
    start |-> lock_q == fwek_pkg::FWEK_OPEN)
    else $error("operation started while locked");
  AST_STALL: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && start |=> cpu_stall)
    else $error("no stall during operation");
  AST_ERASE_KIND: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && start |=> flash.req && flash.erase == $past(psc_q[fwek_pkg::ERASE_BIT]))
    else $error("erase flag wrong");
  AST_READ_ZERO: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && sfr.rd && sfr.addr == fwek_pkg::PSC_ADDR |=> sfr_rdata[7:3] == 5'b00000)
    else $error("upper bits not zero");
  AST_RELOCK: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && done && lock_q == fwek_pkg::FWEK_OPEN && !key_wr && !attempt
    |=> lock_q == fwek_pkg::FWEK_LOCKED)
    else $error("no relock after operation");
  AST_ERR_RESET: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && attempt && !vmon_enabled |=> flash_error_reset)
    else $error("missing Flash error reset");

  // One key sequence buys exactly one operation
  AST_ONE_OP: assert property (@(posedge sys_clk) disable iff (reset)
    done |-> !start)
    else $error("second operation started on one key");
  AST_FIRST_KEY: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && key_wr && !attempt && lock_q == fwek_pkg::FWEK_LOCKED
    && sfr.wdata == fwek_pkg::KEY_FIRST |=> lock_q == fwek_pkg::FWEK_FIRST)
    else $error("first key not taken");
  AST_SECOND_KEY: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && key_wr && !attempt && lock_q == fwek_pkg::FWEK_FIRST
    && sfr.wdata == fwek_pkg::KEY_SECOND |=> lock_q == fwek_pkg::FWEK_OPEN)
    else $error("second key did not unlock");
  AST_BAD_SECOND: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && key_wr && lock_q == fwek_pkg::FWEK_FIRST
    && sfr.wdata != fwek_pkg::KEY_SECOND |=> lock_q == fwek_pkg::FWEK_DEAD)
    else $error("wrong second key did not lock");
  AST_WRITE_OFF: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && xwr_req && !psc_q[fwek_pkg::WRITE_BIT] |=> !flash.req && !flash_error_reset)
    else $error("write reached Flash with write enable clear");
  AST_ERASE_OFF: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && start && !psc_q[fwek_pkg::ERASE_BIT] |=> !flash.erase)
    else $error("erase with erase enable clear");
  AST_SECTOR: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && start |=> flash.scratch == $past(psc_q[fwek_pkg::SCRATCHPAD_SELECT_BIT]))
    else $error("operation sent to wrong sector");
  AST_KEY_READ: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && sfr.rd && sfr.addr == fwek_pkg::KEY_ADDR |=> sfr_rdata[7:2] == 6'h00)
    else $error("key read upper bits not zero");
  AST_ERR_ONLY: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && !attempt |=> !flash_error_reset)
    else $error("error reset without an attempt");
endmodule

// ---- verification/fwek_flash_model.sv ----
// Flash array stand-in: counts program and erase requests it receives
`timescale 1ns/100ps
module fwek_flash_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // Request from the control block
  input wire fwek_pkg::fwek_flash_t flash,
  output logic [7:0] op_count
);
  // Count only, the array contents are not needed to judge the lock logic
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      op_count <= 8'h00;
    end else if (flash.req) begin
      op_count <= op_count + 8'h01;
    end
  end
endmodule

// ---- verification/fwek_flash_ctrl_tb.sv ----
// Testbench for the Flash write/erase control block
`timescale 1ns/100ps
module fwek_flash_ctrl_tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  fwek_pkg::fwek_sfr_t sfr = '0;
  logic xwr_req = 1'b0;
  logic [15:0] xwr_addr = 16'h0000;
  logic [7:0] xwr_data = 8'h00;
  logic [7:0] sfr_rdata;
  logic [7:0] ops;
  logic code_rd = 1'b0;
  logic vmon = 1'b1;
  logic vmon_rst = 1'b1;
  logic clk_en = 1'b1;
  fwek_pkg::fwek_flash_t flash;
  logic code_scratch, xwr_to_flash, cpu_stall, err_rst;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;
  fwek_flash_ctrl #(.WRITE_CYCLES(5), .ERASE_CYCLES(20)) DUT (.sys_clk(sys_clk), .reset(reset),
    .clk_en(clk_en), .sfr(sfr), .sfr_rdata(sfr_rdata), .xwr_req(xwr_req), .xwr_addr(xwr_addr),
    .xwr_data(xwr_data), .code_rd(code_rd), .vmon_enabled(vmon), .vmon_reset_enabled(vmon_rst),
    .flash(flash), .code_scratch(code_scratch), .xwr_to_flash(xwr_to_flash),
    .cpu_stall(cpu_stall), .flash_error_reset(err_rst));
  fwek_flash_model MODEL (.sys_clk(sys_clk), .reset(reset), .flash(flash), .op_count(ops));
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic do_reset();
    reset = 1'b1;
    repeat (16) tick();
    reset = 1'b0;
  endtask
  task automatic sfr_wr(logic [7:0] a, logic [7:0] d);
    tick();
    sfr = '{1'b1, 1'b0, a, d};
    tick();
    sfr = '0;
  endtask
  task automatic sfr_rd(logic [7:0] a, logic [7:0] exp);
    tick();
    sfr = '{1'b0, 1'b1, a, 8'h00};
    tick();
    sfr = '0;
    chk("sfr_rdata", 32'(exp), 32'(sfr_rdata));
  endtask
  task automatic unlock();
    sfr_wr(fwek_pkg::KEY_ADDR, fwek_pkg::KEY_FIRST);
    sfr_rd(fwek_pkg::KEY_ADDR, 8'h01);
    sfr_wr(fwek_pkg::KEY_ADDR, fwek_pkg::KEY_SECOND);
    sfr_rd(fwek_pkg::KEY_ADDR, 8'h02);
  endtask
  // Stall wait is bounded so a stuck busy flag ends as a mismatch
  task automatic flash_op(logic [15:0] a, logic [7:0] d, logic e, logic s, logic go, logic er);
    int n;
    tick();
    xwr_req = 1'b1;
    xwr_addr = a;
    xwr_data = d;
    tick();
    xwr_req = 1'b0;
    chk("cpu_stall", 32'(go), 32'(cpu_stall));
    chk("err_rst", 32'(er), 32'(err_rst));
    if (go) chk("flash", 32'({1'b1, e, s, a, d}), 32'(flash));
    else chk("flash_req", 32'(0), 32'(flash.req));
    n = 0;
    while (cpu_stall !== 1'b0 && n < 100) begin
      tick();
      n++;
    end
    chk("stall_end", 32'(0), 32'(cpu_stall));
  endtask
  task automatic regs_check();
    sfr_rd(fwek_pkg::PSC_ADDR, fwek_pkg::PSC_RESET);
    sfr_rd(fwek_pkg::KEY_ADDR, fwek_pkg::KEY_RESET);
    sfr_wr(fwek_pkg::PSC_ADDR, 8'hFF);
    sfr_rd(fwek_pkg::PSC_ADDR, 8'h07);
    chk("xwr_to_flash", 32'(1), 32'(xwr_to_flash));
    sfr_wr(fwek_pkg::PSC_ADDR, 8'h00);
    chk("xwr_to_flash", 32'(0), 32'(xwr_to_flash));
    flash_op(16'h0010, 8'h77, 1'b0, 1'b0, 1'b0, 1'b0);
    sfr_rd(fwek_pkg::KEY_ADDR, 8'h00);
  endtask
  task automatic write_main();
    sfr_wr(fwek_pkg::PSC_ADDR, 8'h01);
    code_rd = 1'b1;
    tick();
    chk("code_scratch", 32'(0), 32'(code_scratch));
    code_rd = 1'b0;
    unlock();
    flash_op(16'h1234, 8'h5A, 1'b0, 1'b0, 1'b1, 1'b0);
    sfr_rd(fwek_pkg::KEY_ADDR, 8'h00);
    chk("ops", 32'(1), 32'(ops));
  endtask
  task automatic erase_scratch();
    sfr_wr(fwek_pkg::PSC_ADDR, 8'h07);
    code_rd = 1'b1;
    tick();
    chk("code_scratch", 32'(1), 32'(code_scratch));
    code_rd = 1'b0;
    unlock();
    flash_op(16'h0180, 8'h9C, 1'b1, 1'b1, 1'b1, 1'b0);
    sfr_wr(fwek_pkg::PSC_ADDR, 8'h05);
    unlock();
    flash_op(16'h0180, 8'h33, 1'b0, 1'b1, 1'b1, 1'b0);
  endtask
  // Writes made while the clock enable is low must leave the lock untouched
  task automatic freeze_check();
    sfr_wr(fwek_pkg::PSC_ADDR, 8'h01);
    unlock();
    clk_en = 1'b0;
    sfr_wr(fwek_pkg::KEY_ADDR, 8'h00);
    sfr_wr(fwek_pkg::PSC_ADDR, 8'h00);
    clk_en = 1'b1;
    sfr_rd(fwek_pkg::KEY_ADDR, 8'h02);
    sfr_rd(fwek_pkg::PSC_ADDR, 8'h01);
    flash_op(16'h0400, 8'h44, 1'b0, 1'b0, 1'b1, 1'b0);
    sfr_rd(fwek_pkg::KEY_ADDR, 8'h00);
  endtask
  task automatic supply_off();
    sfr_wr(fwek_pkg::PSC_ADDR, 8'h01);
    unlock();
    vmon = 1'b0;
    flash_op(16'h2000, 8'h11, 1'b0, 1'b0, 1'b0, 1'b1);
    vmon = 1'b1;
    vmon_rst = 1'b0;
    flash_op(16'h2001, 8'h11, 1'b0, 1'b0, 1'b0, 1'b1);
    vmon_rst = 1'b1;
    sfr_rd(fwek_pkg::KEY_ADDR, 8'h02);
  endtask
  task automatic lock_cases();
    logic [15:0] seq [4] = '{16'h3C3C, 16'hF1F1, 16'hA5A5, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      do_reset();
      sfr_wr(fwek_pkg::PSC_ADDR, 8'h01);
      if (i < 3) sfr_wr(fwek_pkg::KEY_ADDR, seq[i][15:8]);
      if (i < 3) sfr_wr(fwek_pkg::KEY_ADDR, seq[i][7:0]);
      else flash_op(16'h0200, 8'h11, 1'b0, 1'b0, 1'b0, 1'b0);
      sfr_rd(fwek_pkg::KEY_ADDR, 8'h03);
      sfr_wr(fwek_pkg::KEY_ADDR, fwek_pkg::KEY_FIRST);
      sfr_wr(fwek_pkg::KEY_ADDR, fwek_pkg::KEY_SECOND);
      flash_op(16'h0300, 8'h22, 1'b0, 1'b0, 1'b0, 1'b0);
      chk("ops", 32'(0), 32'(ops));
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  initial begin
    do_reset();
    regs_check();
    write_main();
    erase_scratch();
    freeze_check();
    supply_off();
    lock_cases();
    tally_and_finish();
  end
endmodule
